// File: bench/bst_ctl_model.sv
// Behavioural external test controller
module bst_ctl_model
(
  // Timing reference
  input  wire logic ref_clk,
  // Test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  // Test clock idles low between operations
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // One test clock period, 4 ref clocks per phase, tdo taken late in high phase
  task automatic step(input logic m, input logic d, output logic so);
    tms = m;
    tdi = d;
    repeat (4) @(negedge ref_clk);
    tck = 1'h1;
    repeat (3) @(negedge ref_clk);
    so = tdo;
    @(negedge ref_clk);
    tck = 1'h0;
  endtask
  // Five highs then a low, ending in idle
  task automatic to_idle();
    logic s;
    repeat (5) step(1'h1, ~tdi, s);
    step(1'h0, ~tdi, s);
  endtask
  // Full scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic s;
    dout = '0;
    step(1'h1, ~tdi, s);
    if (ir)
      step(1'h1, ~tdi, s);
    step(1'h0, ~tdi, s);
    step(1'h0, ~tdi, s);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], s);
      dout[i] = s;
    end
    step(1'h1, ~tdi, s);
    step(1'h0, ~tdi, s);
  endtask
endmodule

// File: bench/bst_tap_bench.sv
`include "bst_cfg.svh"
// Comparison with count and report
`define BST_CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("BAD %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module bst_tap_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'h0; // System clock
  logic        rst = 1'h1;     // Reset, active high
  logic        tck;            // Test pins
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic        tdo_line;       // Line seen by the controller, inverse while released
  logic [3:0]  pad_in = 4'h0;  // Pads
  logic [3:0]  core_out = 4'h0;
  logic [3:0]  core_oe = 4'h0;
  logic [3:0]  pad_out;
  logic [3:0]  pad_oe;
  logic [31:0] q;              // Scan result
  logic        s;              // Unused sample
  int          error_cnt = 0;
  int          n_compared = 0;
  localparam logic [31:0] ID_EXP = {`BST_ID_VER, `BST_ID_PART, `BST_ID_MFR, `BST_ID_FIXED};
  always #5 ref_clk = ~ref_clk;
  assign tdo_line = tdo_oe ? tdo : ~tdo;
  bst_tap #(.NPADS(4)) i_bst_tap (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .core_out(core_out), .core_oe(core_oe),
    .pad_out(pad_out), .pad_oe(pad_oe));
  bst_ctl_model i_bst_ctl_model (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
  // Counts and verdict
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Identity chain after reset
  task automatic t_ident();
    i_bst_ctl_model.scan(1'h0, 32, 32'h0, q);
    `BST_CHK("idcode", ID_EXP, q)
  endtask
  // Bypass opcode and unknown opcodes give one stage
  task automatic t_bypass();
    for (int op = 5; op < 8; op++)
    begin
      i_bst_ctl_model.scan(1'h1, 3, op, q);
      `BST_CHK("ir capture", 32'h1, q)
      i_bst_ctl_model.scan(1'h0, 8, 32'hB5, q);
      `BST_CHK("bypass", 32'h6A, q)
    end
  endtask
  // Sample, preload, then drive modes
  task automatic t_boundary();
    pad_in = 4'h6;
    core_out = 4'h6;
    i_bst_ctl_model.scan(1'h1, 3, {29'h0, `BST_OP_SAMPLE}, q);
    i_bst_ctl_model.scan(1'h0, 8, 32'h99, q);
    `BST_CHK("sample", 32'h3C, q)
    core_out = 4'h9;
    core_oe = 4'h5;
    repeat (4) @(negedge ref_clk);
    `BST_CHK("func out", 4'h9, pad_out)
    `BST_CHK("func oe", 4'h5, pad_oe)
    i_bst_ctl_model.scan(1'h1, 3, {29'h0, `BST_OP_EXTEST}, q);
    `BST_CHK("extest out", 4'hA, pad_out)
    `BST_CHK("extest oe", 4'hF, pad_oe)
    i_bst_ctl_model.scan(1'h1, 3, {29'h0, `BST_OP_HIGHZ}, q);
    `BST_CHK("highz oe", 4'h0, pad_oe)
    i_bst_ctl_model.scan(1'h1, 3, {29'h0, `BST_OP_CLAMP}, q);
    `BST_CHK("clamp out", 4'hA, pad_out)
    `BST_CHK("clamp oe", 4'hF, pad_oe)
  endtask
  // Abort in mid shift by five highs
  task automatic t_abort();
    i_bst_ctl_model.step(1'h1, 1'h0, s);
    i_bst_ctl_model.step(1'h0, 1'h1, s);
    repeat (4) i_bst_ctl_model.step(1'h0, 1'h1, s);
    repeat (6) @(negedge ref_clk);
    `BST_CHK("oe shift", 1'h1, tdo_oe)
    i_bst_ctl_model.to_idle();
    repeat (6) @(negedge ref_clk);
    `BST_CHK("oe idle", 1'h0, tdo_oe)
    i_bst_ctl_model.scan(1'h0, 32, 32'h0, q);
    `BST_CHK("idcode again", ID_EXP, q)
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(negedge ref_clk);
    `BST_CHK("reset oe", 4'h0, pad_oe)
    `BST_CHK("reset tdo oe", 1'h0, tdo_oe)
    rst = 1'h0;
    repeat (3) @(negedge ref_clk);
    i_bst_ctl_model.to_idle();
    t_ident();
    t_bypass();
    t_boundary();
    t_abort();
    print_verdict();
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end
endmodule

// File: rtl/bst_cell.sv
`include "bst_cfg.svh"
// One bidirectional pad: an input cell and an output cell
module bst_cell
  import bst_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Scan control
  input  wire logic capture,
  input  wire logic shift,
  input  wire logic update,
  input  wire logic scan_in,
  output logic      scan_out,
  // Pad side
  input  wire logic pin_in,
  input  wire logic core_out,
  input  wire logic drive_test,
  output logic      pin_out
);
  logic in_q,  in_d;   // Observe-only input cell
  logic out_q, out_d;  // Output cell shift stage
  logic upd_q, upd_d;  // Output cell update latch

  // Next values of the cell pair
  always_comb
  begin
    in_d  = in_q;
    out_d = out_q;
    upd_d = upd_q;
    if (capture)
    begin
      in_d  = pin_in;   // see RULE13
      out_d = pin_in;   // see RULE14
    end
    else if (shift)
    begin
      in_d  = scan_in;
      out_d = in_q;
    end
    if (update)
      upd_d = out_q;    // see RULE14
  end

  // Register the cell pair
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      in_q  <= 1'b0;
      out_q <= 1'b0;
      upd_q <= 1'b0;
    end
    else
    begin
      in_q  <= in_d;
      out_q <= out_d;
      upd_q <= upd_d;
    end
  end

  // Input cell never drives; only output cell forces
  assign scan_out = out_q;                               // see RULE12
  assign pin_out  = drive_test ? upd_q : core_out;       // see RULE13
endmodule

// File: rtl/bst_cfg.svh
`ifndef BST_CFG_SVH
`define BST_CFG_SVH
// Instruction width and codes
`define BST_IR_W        3
`define BST_OP_EXTEST   3'h0
`define BST_OP_SAMPLE   3'h1
`define BST_OP_IDCODE   3'h2
`define BST_OP_CLAMP    3'h3
`define BST_OP_HIGHZ    3'h4
`define BST_OP_BYPASS   3'h7
// Capture pattern for instruction register (low bits 01)
`define BST_IR_CAPT     3'h1
// Identity fields (arbitrary values)
`define BST_ID_VER      4'h1
`define BST_ID_PART     16'h1234
`define BST_ID_MFR      11'h0A5
`define BST_ID_FIXED    1'h1
`endif

// File: rtl/bst_pkg.sv
package bst_pkg;
  // Controller states
  typedef enum logic [3:0] {
    BST_RESET, BST_IDLE,
    BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR, BST_PAU_DR, BST_EX2_DR, BST_UPD_DR,
    BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR, BST_PAU_IR, BST_EX2_IR, BST_UPD_IR
  } bst_state_t;
  // Synchronised test pins
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_t;
  // Serial output group
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bst_sout_t;
endpackage

// File: rtl/bst_tap.sv
// Function
// RULE1: Sixteen state synchronous test controller
// RULE2: Reset, idle, data and instruction branch states
// RULE3: Mode select sampled each rising test clock
// RULE4: Separate data and instruction branches
// RULE5: Serial data in on input, out on output
// RULE6: Boundary, identity, bypass, instruction registers
// RULE7: Instruction selects test and data register
// RULE8: Decode EXTEST SAMPLE IDCODE BYPASS CLAMP HIGHZ
// RULE9: Identity holds version, part, maker, fixed bit
// RULE10: Bypass register is one bit
// RULE11: Bypass links input to output directly
// RULE12: Each pad has two chain cells
// RULE13: Input cell observes only, never drives
// RULE14: Output cell captures and forces pin
// RULE15: Standard transitions; five highs reach reset
// RULE16: Output changes on falling edge, shift only
// RULE17: Reset loads identity instruction
`include "bst_cfg.svh"
module bst_tap
  import bst_pkg::*;
#(
  parameter int NPADS = 4
)
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Test pins
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  output logic                  tdo,
  output logic                  tdo_oe,
  // Pads
  input  wire logic [NPADS-1:0] pad_in,
  input  wire logic [NPADS-1:0] core_out,
  input  wire logic [NPADS-1:0] core_oe,
  output logic      [NPADS-1:0] pad_out,
  output logic      [NPADS-1:0] pad_oe
);
  // Next state of the controller
  function automatic bst_state_t bst_next(input bst_state_t s, input logic m); // see RULE2
    case (s)
      BST_RESET:  bst_next = m ? BST_RESET  : BST_IDLE;
      BST_IDLE:   bst_next = m ? BST_SEL_DR : BST_IDLE;
      BST_SEL_DR: bst_next = m ? BST_SEL_IR : BST_CAP_DR; // see RULE4
      BST_CAP_DR: bst_next = m ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR:  bst_next = m ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: bst_next = m ? BST_UPD_DR : BST_PAU_DR;
      BST_PAU_DR: bst_next = m ? BST_EX2_DR : BST_PAU_DR;
      BST_EX2_DR: bst_next = m ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: bst_next = m ? BST_SEL_DR : BST_IDLE;
      BST_SEL_IR: bst_next = m ? BST_RESET  : BST_CAP_IR; // see RULE15
      BST_CAP_IR: bst_next = m ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR:  bst_next = m ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: bst_next = m ? BST_UPD_IR : BST_PAU_IR;
      BST_PAU_IR: bst_next = m ? BST_EX2_IR : BST_PAU_IR;
      BST_EX2_IR: bst_next = m ? BST_UPD_IR : BST_SH_IR;
      default:    bst_next = m ? BST_SEL_DR : BST_IDLE;
    endcase
  endfunction

  localparam int IDW = 32;
  localparam logic [IDW-1:0] ID_VAL = {`BST_ID_VER, `BST_ID_PART, `BST_ID_MFR, `BST_ID_FIXED}; // see RULE9

  bst_pins_t  s1_q, s2_q, s1_d, s2_d;  // Two-stage synchroniser
  logic       tck_old_q, tck_old_d;    // Previous synced clock
  bst_state_t st_q, st_d;              // Controller state
  logic [`BST_IR_W-1:0] irs_q, irs_d;  // Instruction shift stage
  logic [`BST_IR_W-1:0] ir_q, ir_d;    // Active instruction
  logic [IDW-1:0] id_q, id_d;          // Identity chain
  logic       byp_q, byp_d;            // Single bit pass
  bst_sout_t  so_q, so_d;              // Output register
  logic [NPADS-1:0] pout_q, pout_d, poe_q, poe_d;
  logic       rise, fall, cap, sh, upd;
  logic [NPADS:0] chain;
  logic [NPADS-1:0] cell_pin;
  logic [NPADS-1:0] pin_s1_q, pin_s1_d;  // Pad input synchroniser, first stage
  logic [NPADS-1:0] pin_s2_q, pin_s2_d;  // Pad input synchroniser, second stage
  logic       sel_bnd, sel_id, sel_byp, test_drive, hiz, ser_bit;

  assign rise = s2_q.tck & ~tck_old_q;
  assign fall = ~s2_q.tck & tck_old_q;

  // Instruction decode
  assign sel_bnd    = (ir_q == `BST_OP_EXTEST) || (ir_q == `BST_OP_SAMPLE);      // see RULE8
  assign sel_id     = (ir_q == `BST_OP_IDCODE);                                 // see RULE7
  assign sel_byp    = !sel_bnd && !sel_id;                                      // see RULE11
  assign test_drive = (ir_q == `BST_OP_EXTEST) || (ir_q == `BST_OP_CLAMP);
  assign hiz        = (ir_q == `BST_OP_HIGHZ);
  assign cap = rise && (st_q == BST_CAP_DR) && sel_bnd;
  assign sh  = rise && (st_q == BST_SH_DR) && sel_bnd;
  assign upd = rise && (st_q == BST_UPD_DR) && sel_bnd;
  assign chain[0] = s2_q.tdi;

  // Boundary chain, one pair of cells per pad
  genvar g;
  generate
    for (g = 0; g < NPADS; g++)
    begin : g_pad
      bst_cell i_bst_cell (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .capture    (cap),
        .shift      (sh),
        .update     (upd),
        .scan_in    (chain[g]),
        .scan_out   (chain[g+1]),
        .pin_in     (pin_s2_q[g]),
        .core_out   (core_out[g]),
        .drive_test (test_drive),
        .pin_out    (cell_pin[g])
      ); // see RULE12
    end
  endgenerate

  // Serial bit presented at the output
  always_comb
  begin
    ser_bit = byp_q;        // see RULE6
    if (st_q == BST_SH_IR)
      ser_bit = irs_q[0];
    else if (sel_bnd)
      ser_bit = chain[NPADS];
    else if (sel_id)
      ser_bit = id_q[0];
  end

  // Next values of controller and registers
  always_comb
  begin
    s1_d = '{tck: tck, tms: tms, tdi: tdi};
    s2_d = s1_q;
    tck_old_d = s2_q.tck;
    pin_s1_d = pad_in;      // Pads are asynchronous to the system clock
    pin_s2_d = pin_s1_q;
    st_d = st_q;
    irs_d = irs_q;
    ir_d = ir_q;
    id_d = id_q;
    byp_d = byp_q;
    so_d = so_q;
    if (rise)
    begin
      st_d = bst_next(st_q, s2_q.tms);                 // see RULE3
      case (st_q)
        BST_RESET:  ir_d = `BST_OP_IDCODE;             // see RULE17
        BST_CAP_IR: irs_d = `BST_IR_CAPT;
        BST_SH_IR:  irs_d = {s2_q.tdi, irs_q[`BST_IR_W-1:1]}; // see RULE5
        BST_UPD_IR: ir_d = irs_q;                      // see RULE7
        BST_CAP_DR:
        begin
          id_d = ID_VAL;
          byp_d = 1'b0;
        end
        BST_SH_DR:
        begin
          id_d = {s2_q.tdi, id_q[IDW-1:1]};
          byp_d = s2_q.tdi;                            // see RULE10
        end
        default:
        begin
          ir_d = ir_q;
        end
      endcase
    end
    if (fall)
    begin
      so_d.tdo_oe = (st_q == BST_SH_DR) || (st_q == BST_SH_IR); // see RULE16
      so_d.tdo = ser_bit;
    end
    pout_d = hiz ? '0 : cell_pin;
    poe_d  = hiz ? '0 : (test_drive ? {NPADS{1'b1}} : core_oe);
  end

  // Register everything
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      tck_old_q <= 1'b0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      st_q <= BST_RESET;
      irs_q <= '0;
      ir_q <= `BST_OP_IDCODE;
      id_q <= '0;
      byp_q <= 1'b0;
      so_q <= '0;
      pout_q <= '0;
      poe_q <= '0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      tck_old_q <= tck_old_d;
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      st_q <= st_d;       // see RULE1
      irs_q <= irs_d;
      ir_q <= ir_d;
      id_q <= id_d;
      byp_q <= byp_d;
      so_q <= so_d;
      pout_q <= pout_d;
      poe_q <= poe_d;
    end
  end

  assign tdo = so_q.tdo;
  assign tdo_oe = so_q.tdo_oe;
  assign pad_out = pout_q;
  assign pad_oe = poe_q;

  // Select-IR with mode-select high escapes to reset
  reset_walk_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE15
    (rise && st_q == BST_SEL_IR && s2_q.tms) |=> (st_q == BST_RESET)) else $error("select ir escape missed");
  logic [2:0] hi_cnt_q, hi_cnt_d;  // Run of high mode-select samples
  // Count high samples, saturating at five
  always_comb
  begin
    hi_cnt_d = hi_cnt_q;
    if (rise)
      hi_cnt_d = s2_q.tms ? ((hi_cnt_q == 3'h5) ? 3'h5 : hi_cnt_q + 3'h1) : 3'h0;
  end
  // Register the run counter
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      hi_cnt_q <= 3'h0;
    else
      hi_cnt_q <= hi_cnt_d;
  end
  five_high_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE15
    (hi_cnt_q == 3'h5) |-> (st_q == BST_RESET)) else $error("five highs miss reset");
  sequence upd_ir_s;
    rise && st_q == BST_UPD_IR;
  endsequence
  ir_load_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE7
    upd_ir_s |=> (ir_q == $past(irs_q))) else $error("instruction not loaded");
  reset_ir_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE17
    (rise && st_q == BST_RESET) |=> (ir_q == `BST_OP_IDCODE)) else $error("reset ir wrong");
  tdo_float_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE16
    (fall && st_q != BST_SH_DR && st_q != BST_SH_IR) |=> !tdo_oe) else $error("tdo driven");
  tdo_edge_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE16
    (!fall && $past(fall) == 1'b0) |=> $stable(tdo)) else $error("tdo moved");
  bypass_path_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE11
    (rise && st_q == BST_SH_DR && sel_byp) |=> (byp_q == $past(s2_q.tdi))) else $error("bypass");
  cap_id_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE9
    (rise && st_q == BST_CAP_DR) |=> (id_q == ID_VAL)) else $error("id capture");
  highz_pads_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE8
    hiz [*2] |=> (pad_oe == '0)) else $error("highz drives");
  clamp_drive_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE14
    (ir_q == `BST_OP_CLAMP) [*2] |=> (pad_oe == {NPADS{1'b1}})) else $error("clamp");
endmodule
